//--- rtl/csf_pkg.sv
// Notes on behaviour
// - RGB output types 0x24, 0x23, 0x22 for formats 0000-0010, input 00.
// - YUV types 0x1A, 0x18, 0x1E, 0x1C for formats 0011, 0100, 0101, 1001.
// - Input 11 gives RAW8 0x2A, RAW10 0x2B, RAW12 0x2C for 0110-1000.
// - Output format in config bits 7:4, input format in bits 3:2.
// - Indirect register 0x09 bit 4 sets RAW bit alignment in payload.
// - Colour conversion exists only from RGB input to YUV output.
// - Control bit 1 selects continuous or non-continuous clock lane.
// - Reset leaves the clock lane in non-continuous mode.
// - Non-continuous clock stops in vertical blanking, and between lines if horizontal blanking is long.
// - Non-continuous clock lane goes LP-11 in blanking after a line whose preceding horizontal blanking exceeded 96 cycles.
// - Software standby bit 2 of control asks the lanes into ULPS.
// - ULPS puts clock lane and all data lanes into ultra-low-power.
// - Data lanes enter ULPS through escape mode, then command 00011110.
// - ULPS exit drives Mark-1 for the wake-up time, then Stop.
// - Identifier byte holds channel in bits 7:6 and data type below.
// - Virtual channel comes from indirect register 0x2E bits 7:6.
// - End of vertical sync sends frame-end then frame-start short packets.
// - Display-enable rise starts one long packet; data lanes then return to LP-11.
package csf_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // Register indices, byte address is index times four
   localparam logic [7:0] IDX_CTRL      = 8'h6A;
   localparam logic [7:0] IDX_CFG       = 8'h6B;
   localparam logic [7:0] IDX_IA_PAGE   = 8'h6C;
   localparam logic [7:0] IDX_IA_DATA   = 8'h6D;
   localparam logic [7:0] IDX_STATUS    = 8'h6E;
   localparam logic [7:0] IA_RAW_ALIGN  = 8'h09;
   localparam logic [7:0] IA_VC_ID      = 8'h2E;
   // Field positions
   localparam int CTRL_CONT_BIT  = 1;
   localparam int CTRL_STBY_BIT  = 2;
   localparam int CFG_OUTPUT_FORMAT_SELECT_LSB   = 4;
   localparam int CFG_INPUT_FORMAT_SELECT_LSB   = 2;
   localparam int IA_ALIGN_BIT   = 4;
   localparam int IA_VC_LSB      = 6;
   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] CFG_RST  = 8'h00;
   localparam logic [7:0] IA_RST   = 8'h00;
   // Formats and data types
   localparam logic [1:0] INPUT_FORMAT_SELECT_RGB = 2'h0;
   localparam logic [1:0] INPUT_FORMAT_SELECT_RAW = 2'h3;
   localparam logic [5:0] DT_FS    = 6'h00;
   localparam logic [5:0] DT_FE    = 6'h01;
   localparam logic [7:0] ULPS_CMD = 8'h1E;
   localparam logic [7:0] HBLANK_THRESH = 8'h60;
   localparam logic [1:0] LP11 = 2'h3;
   localparam logic [1:0] LP10 = 2'h2;
   localparam logic [1:0] LP01 = 2'h1;
   localparam logic [1:0] LP00 = 2'h0;

   typedef enum logic [2:0] {
      ST_RUN, ST_ESC_ENTRY, ST_ESC_CMD, ST_ULPS, ST_WAKE, ST_STOP
   } csf_lane_st_t;

   // Valid flag in bit 6, data type below
   function automatic logic [6:0] csf_dt_map(input logic [1:0] input_format_select,
                                             input logic [3:0] output_format_select);
      logic [6:0] r;
      r = 7'h00;
      if (input_format_select == INPUT_FORMAT_SELECT_RGB) begin
         case (output_format_select)
            4'h0:    r = 7'h64;
            4'h1:    r = 7'h63;
            4'h2:    r = 7'h62;
            4'h3:    r = 7'h5A;
            4'h4:    r = 7'h58;
            4'h5:    r = 7'h5E;
            4'h9:    r = 7'h5C;
            default: r = 7'h00;
         endcase
      end else if (input_format_select == INPUT_FORMAT_SELECT_RAW) begin
         case (output_format_select)
            4'h6:    r = 7'h6A;
            4'h7:    r = 7'h6B;
            4'h8:    r = 7'h6C;
            default: r = 7'h00;
         endcase
      end
      return r;
   endfunction

   function automatic logic csf_is_yuv(input logic [3:0] output_format_select);
      return (output_format_select >= 4'h3 && output_format_select <= 4'h5) || output_format_select == 4'h9;
   endfunction
endpackage

//--- rtl/csf_sync.sv
`timescale 1ns/1ns
module csf_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   // Data
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } csf_sync_t;

   csf_sync_t r;
   csf_sync_t next_r;

   always_comb begin
      next_r    = r;
      next_r.s1 = d_in;
      next_r.s2 = r.s1;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign q_out = r.s2;
endmodule // csf_sync

//--- rtl/csf_top.sv
`timescale 1ns/1ns
module csf_top #(
   parameter int WAKE_CYCLES = 1024
) (
   // Register bus
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   input  wire logic [3:0]  pstrb_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // Video, link clock domain
   input  wire logic        link_clk_in,
   input  wire logic        display_enable_in,
   input  wire logic        vertical_sync_in,
   input  wire logic [23:0] pixel_data_in,
   // Packets
   output logic             pkt_start_out,
   output logic             pkt_long_out,
   output logic      [7:0]  pkt_di_out,
   output logic      [11:0] pkt_pixels_out,
   output logic             pay_valid_out,
   output logic      [23:0] pay_data_out,
   output logic             csc_enable_out,
   // Lanes
   output logic             clk_lane_hs_out,
   output logic      [1:0]  clk_lane_lp_out,
   output logic             data_lane_hs_out,
   output logic      [1:0]  data_lane_lp_out,
   output logic             esc_bit_out,
   output logic             esc_valid_out
);
   localparam int SHW = 11;

   typedef struct packed {
      logic            cont;
      logic            stby;
      logic [3:0]      output_format_select;
      logic [1:0]      input_format_select;
      logic [7:0]      ia_page;
      logic [7:0]      ia_align;
      logic [7:0]      ia_vc;
      logic [SHW-1:0]  shadow;
      logic            req;
      logic [31:0]     prdata;
      logic            pready;
      logic            pslverr;
   } csf_bus_t;

   typedef struct packed {
      logic [3:0]      output_format_select;
      logic [1:0]      input_format_select;
      logic            align;
      logic [1:0]      vc;
      logic            cont;
      logic            stby;
      logic            ack;
      logic            de_d;
      logic            vs_d;
      logic [7:0]      hb_cnt;
      logic            hb_long;
      logic [11:0]     line_cnt;
      logic [11:0]     line_len;
      logic            fs_pend;
      csf_pkg::csf_lane_st_t st;
      logic [15:0]     ucnt;
      logic            ulps;
      logic            pkt_start;
      logic            pkt_long;
      logic [7:0]      pkt_di;
      logic [11:0]     pkt_pixels;
      logic            pay_valid;
      logic [23:0]     pay_data;
      logic            csc_en;
      logic            clk_hs;
      logic [1:0]      clk_lp;
      logic            dat_hs;
      logic [1:0]      dat_lp;
      logic            esc_bit;
      logic            esc_valid;
   } csf_link_t;

   csf_bus_t   b;
   csf_bus_t   next_b;
   csf_link_t  l;
   csf_link_t  next_l;
   logic       ack_s;
   logic       req_s;
   logic [1:0] stat_s;
   logic [6:0] bmap;
   logic [6:0] lmap;

   ////////////////////////////////////////////////////////////////////////////
   // Crossings
   csf_sync #(.W(1)) u_ack_sync (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .d_in     (l.ack),
      .q_out    (ack_s)
   );

   csf_sync #(.W(1)) u_req_sync (
      .clk_in   (link_clk_in),
      .rst_n_in (rst_n_in),
      .d_in     (b.req),
      .q_out    (req_s)
   );

   csf_sync #(.W(2)) u_stat_sync (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .d_in     ({l.clk_hs, l.ulps}),
      .q_out    (stat_s)
   );

   assign bmap = csf_pkg::csf_dt_map(b.input_format_select, b.output_format_select);
   assign lmap = csf_pkg::csf_dt_map(l.input_format_select, l.output_format_select);

   ////////////////////////////////////////////////////////////////////////////
   // Register bus side
   always_comb begin
      logic [7:0]     idx;
      logic           hit;
      logic [SHW-1:0] live;
      idx  = paddr_in[9:2];
      hit  = paddr_in[11:10] == 2'h0 &&
             (idx == csf_pkg::IDX_CTRL || idx == csf_pkg::IDX_CFG ||
              idx == csf_pkg::IDX_IA_PAGE || idx == csf_pkg::IDX_IA_DATA ||
              idx == csf_pkg::IDX_STATUS);
      live = {b.output_format_select, b.input_format_select, b.ia_align[csf_pkg::IA_ALIGN_BIT],
              b.ia_vc[csf_pkg::IA_VC_LSB +: 2], b.cont, b.stby};
      next_b         = b;
      next_b.pready  = 1'b0;
      next_b.pslverr = 1'b0;
      next_b.prdata  = 32'h0000_0000;
      if (psel_in && !penable_in) begin
         next_b.pready  = 1'b1;
         next_b.pslverr = !hit;
         if (idx == csf_pkg::IDX_CTRL && hit) begin
            next_b.prdata[csf_pkg::CTRL_CONT_BIT] = b.cont;
            next_b.prdata[csf_pkg::CTRL_STBY_BIT] = b.stby;
         end else if (idx == csf_pkg::IDX_CFG && hit) begin
            next_b.prdata[7:0] = {b.output_format_select, b.input_format_select, 2'h0};
         end else if (idx == csf_pkg::IDX_IA_PAGE && hit) begin
            next_b.prdata[7:0] = b.ia_page;
         end else if (idx == csf_pkg::IDX_IA_DATA && hit) begin
            if (b.ia_page == csf_pkg::IA_RAW_ALIGN) begin
               next_b.prdata[7:0] = b.ia_align;
            end else if (b.ia_page == csf_pkg::IA_VC_ID) begin
               next_b.prdata[7:0] = b.ia_vc;
            end
         end else if (idx == csf_pkg::IDX_STATUS && hit) begin
            next_b.prdata[2:0] = {bmap[6], stat_s};
         end
      end
      if (psel_in && penable_in && b.pready && pwrite_in && pstrb_in[0]
          && hit) begin
         if (idx == csf_pkg::IDX_CTRL) begin
            next_b.cont = pwdata_in[csf_pkg::CTRL_CONT_BIT];
            next_b.stby = pwdata_in[csf_pkg::CTRL_STBY_BIT];
         end else if (idx == csf_pkg::IDX_CFG) begin
            next_b.output_format_select = pwdata_in[csf_pkg::CFG_OUTPUT_FORMAT_SELECT_LSB +: 4];
            next_b.input_format_select = pwdata_in[csf_pkg::CFG_INPUT_FORMAT_SELECT_LSB +: 2];
         end else if (idx == csf_pkg::IDX_IA_PAGE) begin
            next_b.ia_page = pwdata_in[7:0];
         end else if (idx == csf_pkg::IDX_IA_DATA) begin
            if (b.ia_page == csf_pkg::IA_RAW_ALIGN) begin
               next_b.ia_align = pwdata_in[7:0];
            end else if (b.ia_page == csf_pkg::IA_VC_ID) begin
               next_b.ia_vc = pwdata_in[7:0];
            end
         end
      end
      // Handshake new settings over once the last one was taken
      if (ack_s == b.req && live != b.shadow) begin
         next_b.shadow = live;
         next_b.req    = !b.req;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         b          <= '0;
         b.cont     <= csf_pkg::CTRL_RST[csf_pkg::CTRL_CONT_BIT];
         b.stby     <= csf_pkg::CTRL_RST[csf_pkg::CTRL_STBY_BIT];
         b.output_format_select     <= csf_pkg::CFG_RST[csf_pkg::CFG_OUTPUT_FORMAT_SELECT_LSB +: 4];
         b.input_format_select     <= csf_pkg::CFG_RST[csf_pkg::CFG_INPUT_FORMAT_SELECT_LSB +: 2];
         b.ia_align <= csf_pkg::IA_RST;
         b.ia_vc    <= csf_pkg::IA_RST;
      end else begin
         b <= next_b;
      end
   end

   assign prdata_out  = b.prdata;
   assign pready_out  = b.pready;
   assign pslverr_out = b.pslverr;

   ////////////////////////////////////////////////////////////////////////////
   // Link side
   always_comb begin
      logic send;
      send = l.st == csf_pkg::ST_RUN && lmap[6];
      next_l           = l;
      next_l.pkt_start = 1'b0;
      next_l.pay_valid = 1'b0;
      next_l.esc_valid = 1'b0;
      next_l.esc_bit   = 1'b0;
      next_l.de_d      = display_enable_in;
      next_l.vs_d      = vertical_sync_in;
      if (req_s != l.ack) begin
         {next_l.output_format_select, next_l.input_format_select, next_l.align, next_l.vc,
          next_l.cont, next_l.stby} = b.shadow;
         next_l.ack = req_s;
      end
      // Blanking and line length measurement
      if (vertical_sync_in) begin
         next_l.hb_cnt = 8'h00;
      end else if (!display_enable_in && l.hb_cnt != 8'hFF) begin
         next_l.hb_cnt = l.hb_cnt + 8'h01;
      end
      if (display_enable_in && !l.de_d) begin
         next_l.hb_long = l.hb_cnt > csf_pkg::HBLANK_THRESH;
         next_l.hb_cnt  = 8'h00;
      end
      if (display_enable_in) begin
         next_l.line_cnt = l.line_cnt + 12'h001;
      end else if (l.de_d) begin
         next_l.line_len = l.line_cnt;
         next_l.line_cnt = 12'h000;
      end
      // Packets
      if (send && l.vs_d && !vertical_sync_in) begin
         next_l.pkt_start = 1'b1;
         next_l.pkt_long  = 1'b0;
         next_l.pkt_di    = {l.vc, csf_pkg::DT_FE};
         next_l.fs_pend   = 1'b1;
      end else if (send && l.fs_pend) begin
         next_l.pkt_start = 1'b1;
         next_l.pkt_long  = 1'b0;
         next_l.pkt_di    = {l.vc, csf_pkg::DT_FS};
         next_l.fs_pend   = 1'b0;
      end else if (send && display_enable_in && !l.de_d) begin
         next_l.pkt_start  = 1'b1;
         next_l.pkt_long   = 1'b1;
         next_l.pkt_di     = {l.vc, lmap[5:0]};
         next_l.pkt_pixels = l.line_len;
      end
      if (send && display_enable_in) begin
         next_l.pay_valid = 1'b1;
         next_l.pay_data  = pixel_data_in;
         if (l.input_format_select == csf_pkg::INPUT_FORMAT_SELECT_RAW) begin
            next_l.pay_data = 24'h00_0000;
            unique case (l.output_format_select)
               4'h6: next_l.pay_data[11:0] = l.align ?
                     {pixel_data_in[7:0], 4'h0} : {4'h0, pixel_data_in[7:0]};
               4'h7: next_l.pay_data[11:0] = l.align ?
                     {pixel_data_in[9:0], 2'h0} : {2'h0, pixel_data_in[9:0]};
               default: next_l.pay_data[11:0] = pixel_data_in[11:0];
            endcase
         end
      end
      next_l.csc_en = l.input_format_select == csf_pkg::INPUT_FORMAT_SELECT_RGB &&
                      csf_pkg::csf_is_yuv(l.output_format_select);
      // Lane power sequencing
      unique case (l.st)
         csf_pkg::ST_RUN: begin
            if (l.stby && !display_enable_in && !l.fs_pend) begin
               next_l.st   = csf_pkg::ST_ESC_ENTRY;
               next_l.ucnt = 16'h0000;
            end
         end
         csf_pkg::ST_ESC_ENTRY: begin
            next_l.ucnt = l.ucnt + 16'h0001;
            if (l.ucnt == 16'h0003) begin
               next_l.st   = csf_pkg::ST_ESC_CMD;
               next_l.ucnt = 16'h0000;
            end
         end
         csf_pkg::ST_ESC_CMD: begin
            next_l.ucnt = l.ucnt + 16'h0001;
            if (l.ucnt == 16'h0007) begin
               next_l.st = csf_pkg::ST_ULPS;
            end
         end
         csf_pkg::ST_ULPS: begin
            if (!l.stby) begin
               next_l.st   = csf_pkg::ST_WAKE;
               next_l.ucnt = 16'h0000;
            end
         end
         csf_pkg::ST_WAKE: begin
            next_l.ucnt = l.ucnt + 16'h0001;
            if (l.ucnt == 16'(WAKE_CYCLES - 1)) begin
               next_l.st = csf_pkg::ST_STOP;
            end
         end
         csf_pkg::ST_STOP: begin
            next_l.st = csf_pkg::ST_RUN;
         end
      endcase
      next_l.ulps   = next_l.st == csf_pkg::ST_ULPS;
      next_l.clk_lp = csf_pkg::LP11;
      next_l.dat_lp = csf_pkg::LP11;
      unique case (next_l.st)
         csf_pkg::ST_ESC_ENTRY: begin
            unique case (next_l.ucnt[1:0])
               2'h0:    next_l.dat_lp = csf_pkg::LP10;
               2'h2:    next_l.dat_lp = csf_pkg::LP01;
               default: next_l.dat_lp = csf_pkg::LP00;
            endcase
         end
         csf_pkg::ST_ESC_CMD: begin
            next_l.dat_lp    = csf_pkg::LP00;
            next_l.esc_valid = 1'b1;
            next_l.esc_bit   = csf_pkg::ULPS_CMD[3'h7 - next_l.ucnt[2:0]];
         end
         csf_pkg::ST_ULPS: begin
            next_l.clk_lp = csf_pkg::LP00;
            next_l.dat_lp = csf_pkg::LP00;
         end
         csf_pkg::ST_WAKE: begin
            next_l.clk_lp = csf_pkg::LP10;
            next_l.dat_lp = csf_pkg::LP10;
         end
         default: begin
         end
      endcase
      // In run state the clock lane stays HS unless blanking allows a stop
      next_l.clk_hs = next_l.st == csf_pkg::ST_RUN &&
                      (l.cont || (!vertical_sync_in &&
                       (display_enable_in || !l.hb_long ||
                        next_l.pkt_start || l.fs_pend)));
      next_l.dat_hs = next_l.pkt_start || next_l.pay_valid;
   end

   always_ff @(posedge link_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         l        <= '0;
         l.st     <= csf_pkg::ST_RUN;
         l.clk_lp <= csf_pkg::LP11;
         l.dat_lp <= csf_pkg::LP11;
      end else begin
         l <= next_l;
      end
   end

   assign pkt_start_out    = l.pkt_start;
   assign pkt_long_out     = l.pkt_long;
   assign pkt_di_out       = l.pkt_di;
   assign pkt_pixels_out   = l.pkt_pixels;
   assign pay_valid_out    = l.pay_valid;
   assign pay_data_out     = l.pay_data;
   assign csc_enable_out   = l.csc_en;
   assign clk_lane_hs_out  = l.clk_hs;
   assign clk_lane_lp_out  = l.clk_lp;
   assign data_lane_hs_out = l.dat_hs;
   assign data_lane_lp_out = l.dat_lp;
   assign esc_bit_out      = l.esc_bit;
   assign esc_valid_out    = l.esc_valid;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_ulps_cmd;
      (esc_valid_out && !esc_bit_out) [*3] ##1
      (esc_valid_out && esc_bit_out) [*4] ##1
      (esc_valid_out && !esc_bit_out);
   endsequence

   sequence s_fe_fs;
      (pkt_start_out && !pkt_long_out && pkt_di_out[5:0] == 6'h01) ##1
      (pkt_start_out && !pkt_long_out && pkt_di_out[5:0] == 6'h00);
   endsequence

   chk_ulps_cmd: assert property (@(posedge link_clk_in)
      disable iff (!rst_n_in) $rose(esc_valid_out) |-> s_ulps_cmd)
      else $error("ULPS entry command bits wrong");

   chk_ulps_lanes: assert property (@(posedge link_clk_in)
      disable iff (!rst_n_in) l.st == csf_pkg::ST_ULPS |->
      clk_lane_lp_out == 2'h0 && data_lane_lp_out == 2'h0 && !clk_lane_hs_out)
      else $error("Lanes not in ULPS while in ULPS state");

   chk_wake_exit: assert property (@(posedge link_clk_in)
      disable iff (!rst_n_in) $rose(l.st == csf_pkg::ST_STOP) |->
      $past(data_lane_lp_out) == 2'h2 && $past(l.ucnt) == WAKE_CYCLES - 1
      && data_lane_lp_out == 2'h3 ##1 l.st == csf_pkg::ST_RUN)
      else $error("ULPS exit not Mark-1 then Stop");

   chk_cont_clock: assert property (@(posedge link_clk_in)
      disable iff (!rst_n_in) l.st == csf_pkg::ST_RUN && $past(l.cont) &&
      $past(l.st) == csf_pkg::ST_RUN |-> clk_lane_hs_out)
      else $error("Continuous clock lane stopped");

   chk_vblank_stop: assert property (@(posedge link_clk_in)
      disable iff (!rst_n_in) !l.cont && vertical_sync_in |=> !clk_lane_hs_out)
      else $error("Clock lane running in vertical blanking");

   chk_hblank_stop: assert property (@(posedge link_clk_in)
      disable iff (!rst_n_in) !l.cont && l.hb_long && !display_enable_in &&
      !vertical_sync_in && !l.vs_d && !l.fs_pend |=> !clk_lane_hs_out)
      else $error("Clock lane not stopped in long blanking");

   chk_di_long: assert property (@(posedge link_clk_in)
      disable iff (!rst_n_in) pkt_start_out && pkt_long_out |->
      pkt_di_out == {$past(l.vc), $past(lmap[5:0])})
      else $error("Long packet identifier mismatch");

   chk_no_reserved: assert property (@(posedge link_clk_in)
      disable iff (!rst_n_in) pkt_start_out |-> $past(lmap[6]))
      else $error("Packet sent with reserved format");

   chk_frame_pkts: assert property (@(posedge link_clk_in)
      disable iff (!rst_n_in) $fell(vertical_sync_in) && l.vs_d &&
      l.st == csf_pkg::ST_RUN && lmap[6] && !l.fs_pend |=> s_fe_fs)
      else $error("Frame end and start packets missing");

   chk_line_long: assert property (@(posedge link_clk_in)
      disable iff (!rst_n_in) $rose(display_enable_in) && !l.de_d &&
      l.st == csf_pkg::ST_RUN && lmap[6] && !l.fs_pend &&
      !(l.vs_d && !vertical_sync_in) |=> pkt_start_out && pkt_long_out)
      else $error("Line did not start a long packet");

   chk_apb_answer: assert property (@(posedge clk_in)
      disable iff (!rst_n_in) psel_in && !penable_in |=>
      pready_out ##1 !pready_out)
      else $error("Bus answer not one cycle after setup");

   chk_ctrl_write: assert property (@(posedge clk_in)
      disable iff (!rst_n_in) psel_in && penable_in && pready_out &&
      pwrite_in && pstrb_in[0] && paddr_in == 12'h1A8 |=>
      b.cont == $past(pwdata_in[1]) && b.stby == $past(pwdata_in[2]))
      else $error("Control write not stored");
endmodule // csf_top

//--- verif/csf_rx_model.sv
`timescale 1ns/1ns
module csf_rx_model (
   // Link side
   input  wire logic       link_clk_in,
   input  wire logic       pkt_start_in,
   input  wire logic       pkt_long_in,
   input  wire logic [7:0] pkt_di_in,
   input  wire logic       esc_bit_in,
   input  wire logic       esc_valid_in,
   // Receiver view
   output int              n_long_out,
   output int              n_short_out,
   output logic      [7:0] di_out,
   output logic      [7:0] esc_cmd_out
);
   initial begin
      n_long_out = 0;
      n_short_out = 0;
      di_out = 8'h00;
      esc_cmd_out = 8'h00;
   end
   always @(posedge link_clk_in) begin
      if (pkt_start_in) begin
         di_out <= pkt_di_in;
         if (pkt_long_in) n_long_out <= n_long_out + 1;
         else n_short_out <= n_short_out + 1;
      end
      // First escape bit lands in the top
      if (esc_valid_in) esc_cmd_out <= {esc_cmd_out[6:0], esc_bit_in};
   end
endmodule // csf_rx_model

//--- verif/tb_csi2_output_format_and_lane_power.sv
`timescale 1ns/1ns
module tb_csi2_output_format_and_lane_power;
   logic        clk = 1'b0, lclk = 1'b0, rst_n = 1'b0, de = 1'b0, vs = 1'b0;
   logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, rd, rv, pay;
   logic        err, ev_err, rdy, lhs, ev, eb, ps, pl, dhs, pv, csc;
   logic [1:0]  clp, dlp;
   logic [7:0]  di, esc;
   logic [11:0] pix;
   logic [23:0] pd;
   int          errors = 0, n_compared = 0, nl, ns, k;
   logic [11:0] tbl [12] = '{{2'd0,4'h0,6'h24}, {2'd0,4'h1,6'h23},
      {2'd0,4'h2,6'h22}, {2'd0,4'h3,6'h1A}, {2'd0,4'h4,6'h18},
      {2'd0,4'h5,6'h1E}, {2'd3,4'h6,6'h2A}, {2'd3,4'h7,6'h2B},
      {2'd3,4'h8,6'h2C}, {2'd0,4'h9,6'h1C}, {2'd0,4'hA,6'h00},
      {2'd0,4'h6,6'h00}};
   csf_top #(.WAKE_CYCLES(8)) csf_top_i (.clk_in(clk), .rst_n_in(rst_n),
      .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
      .pwdata_in(pwdata), .pstrb_in(4'hF), .prdata_out(rd),
      .pready_out(rdy), .pslverr_out(err), .link_clk_in(lclk),
      .display_enable_in(de), .vertical_sync_in(vs),
      .pixel_data_in(24'hA5_5A5A), .pkt_start_out(ps), .pkt_long_out(pl),
      .pkt_di_out(di), .pkt_pixels_out(pix), .pay_valid_out(pv),
      .pay_data_out(pd), .csc_enable_out(csc), .clk_lane_hs_out(lhs),
      .clk_lane_lp_out(clp), .data_lane_hs_out(dhs),
      .data_lane_lp_out(dlp),
      .esc_bit_out(eb), .esc_valid_out(ev));
   csf_rx_model csf_rx_model_i (.link_clk_in(lclk), .pkt_start_in(ps),
      .pkt_long_in(pl), .pkt_di_in(di), .esc_bit_in(eb), .esc_valid_in(ev),
      .n_long_out(nl), .n_short_out(ns), .di_out(), .esc_cmd_out(esc));
   initial forever #25 clk = ~clk;
   initial begin
      #7;
      forever #32 lclk = ~lclk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         errors++;
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (rdy !== 1'b1);
      rv = rd;
      ev_err = err;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic lw(input int n);
      repeat (n) @(posedge lclk);
   endtask
   task automatic ln();
      @(posedge lclk);
      de <= 1'b1;
      lw(8);
      pay = {6'h00, dhs, pv, pd};
      de <= 1'b0;
      lw(12);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_vs(input logic cont);
      apb(1'b1, 12'h1A8, {30'h0, cont, 1'b0});
      k = ns;
      lw(20);
      vs <= 1'b1;
      lw(10);
      chk("clock lane hs", 32'(cont), 32'(lhs));
      vs <= 1'b0;
      lw(10);
      chk("short count", k + 2, ns);
      chk("frame start type", 32'h0000_0000, 32'(di[5:0]));
   endtask
   task automatic t_map();
      apb(1'b1, 12'h1AC, 32'h0000_0058);
      apb(1'b0, 12'h1AC, 32'h0000_0000);
      chk("config readback", 32'h0000_0058, rv);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk("unmapped error", 32'h0000_0001, 32'(ev_err));
   endtask
   task automatic t_fmt();
      for (int i = 0; i < 12; i++) begin
         apb(1'b1, 12'h1B0, 32'h0000_002E);
         apb(1'b1, 12'h1B4, {24'h0, i[1:0], 6'h00});
         apb(1'b1, 12'h1B0, 32'h0000_0009);
         apb(1'b1, 12'h1B4, {27'h0, i[0], 4'h0});
         apb(1'b1, 12'h1AC, {24'h0, tbl[i][9:6], tbl[i][11:10], 2'b00});
         k = nl;
         lw(20);
         ln();
         chk("long count", (i < 10) ? k + 1 : k, nl);
         chk("csc", 32'((i > 2 && i < 6) || i == 9), 32'(csc));
         chk("line end", 32'h0000_0003, {29'h0, dhs, dlp});
         if (i < 10) begin
            rv = 32'({i[1:0], tbl[i][5:0]});
            chk("identifier", rv, 32'(di));
            chk("pixel count", (i == 0) ? 0 : 8, 32'(pix));
            chk("payload", {8'h03, i == 6 ? 24'h00_005A : i == 7 ? 24'h00_0968 :
                i == 8 ? 24'h00_0A5A : 24'hA5_5A5A}, pay);
         end else begin
            chk("payload idle", 32'h0, {30'h0, pay[25:24]});
         end
      end
   endtask
   task automatic t_ulps();
      apb(1'b1, 12'h1A8, 32'h0000_0004);
      lw(40);
      chk("entry command", 32'h0000_001E, 32'(esc));
      chk("data lanes ulps", 32'h0000_0000, 32'(dlp));
      chk("clock lane ulps", 32'h0000_0000, 32'(clp));
      apb(1'b0, 12'h1B8, 32'h0000_0000);
      chk("status ulps", 32'h0000_0001, rv);
      apb(1'b1, 12'h1A8, 32'h0000_0000);
      for (k = 0; k < 40 && dlp !== 2'b10; k++) @(posedge lclk);
      chk("mark one", 32'h0000_0002, 32'(clp));
      lw(100);
      chk("stop state", 32'h0000_0003, 32'(dlp));
      ln();
      chk("long blank clock", 32'h0000_0000, 32'(lhs));
      ln();
      chk("short blank clock", 32'h0000_0001, 32'(lhs));
   endtask
   task automatic report_and_stop();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #3000000;
      errors++;
      report_and_stop();
   end
   initial begin
      repeat (20) @(posedge clk);
      chk("reset lanes", 32'h0000_000F, 32'({clp, dlp}));
      rst_n <= 1'b1;
      apb(1'b0, 12'h1A8, 32'h0000_0000);
      chk("ctrl reset", 32'h0000_0000, rv);
      t_vs(1'b0);
      t_vs(1'b1);
      t_map();
      t_fmt();
      t_ulps();
      report_and_stop();
   end
endmodule // tb_csi2_output_format_and_lane_power
